// ==== pcs_cfg.svh ====
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
// register indices; byte address is index * 4
`define PCS_IDX_INDIRECT   6'h00
`define PCS_IDX_PC_LOW     6'h02
`define PCS_IDX_STATUS     6'h03
`define PCS_IDX_BANK_PTR   6'h04
`define PCS_IDX_PORT5      6'h05
`define PCS_IDX_PORT6      6'h06
`define PCS_IDX_PORT7      6'h07
`define PCS_IDX_CMP_STAT   6'h09
`define PCS_IDX_RAM_LO     6'h10
`define PCS_IDX_BANKED     6'h20
// status field positions, software-writable status mask and bank pointer bit
`define PCS_ST_RST         7
`define PCS_ST_SEG         6
`define PCS_ST_PAGE        5
`define PCS_ST_TOUT        4
`define PCS_ST_PDOWN       3
`define PCS_ST_ZERO        2
`define PCS_ST_HCARRY      1
`define PCS_ST_CARRY       0
`define PCS_ST_SW_MASK     8'h67
`define PCS_BANK_BIT       6
// reset values, port masks, RAM size and response codes
`define PCS_ST_RESET       8'h18
`define PCS_PC_RESET       11'h000
`define PCS_BYTE_RESET     8'h00
`define PCS_PORT5_SMALL    8'h3F
`define PCS_PORT7_MASK     8'h03
`define PCS_RAM_WORDS      80
`define PCS_RESP_OKAY      2'b00
`define PCS_RESP_SLVERR    2'b10
`endif

// ==== pcs_pkg.sv ====
package pcs_pkg;
  typedef enum logic [3:0] {
    PCS_OP_STEP,
    PCS_OP_JUMP,
    PCS_OP_CALL,
    PCS_OP_RETURN,
    PCS_OP_ADD_PC,
    PCS_OP_MOV_PC,
    PCS_OP_WRITE_PC,
    PCS_OP_INT_ENTRY,
    PCS_OP_SLEEP,
    PCS_OP_WDT_CLEAR,
    PCS_OP_ALU
  } pcs_op_t;

  typedef struct packed {
    pcs_op_t    op;
    logic [9:0] operand;
    logic [7:0] acc;
    logic [7:0] value;
    logic       half_carry;
    logic       carry;
  } pcs_instr_t;

  typedef struct packed {
    logic wake;
    logic by_change;
    logic wdt_timeout;
  } pcs_wake_t;
endpackage : pcs_pkg

// ==== pcs_core.sv ====
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"
module pcs_core #(
  parameter int STACK_DEPTH = 8,
  parameter bit SMALL_PORT5 = 1'b0
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire pcs_pkg::pcs_instr_t instr,
  input  wire logic              instr_valid,
  output var  logic              instr_ready,
  output var  logic [10:0]       rom_addr,
  input  wire pcs_pkg::pcs_wake_t wake_info,
  input  wire logic [3:0]        comparator_result,
  input  wire logic [2:0]        counter_overflow,
  output var  logic              control_segment_select,
  output var  logic [7:0]        port_five_out,
  output var  logic [7:0]        port_six_out,
  output var  logic [1:0]        port_seven_out
);
  import pcs_pkg::*;
  localparam int SPW = $clog2(STACK_DEPTH);
  initial begin
    if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH) begin
      $error("stack depth must be a power of two of at least 2");
    end
  end
  logic [10:0]   pc_ff;
  logic [10:0]   nxt_pc;
  logic [10:0]   stack_ff [STACK_DEPTH];
  logic [SPW-1:0] sp_ff;
  logic          ready_ff;
  logic [7:0]    status_ff;
  logic [7:0]    nxt_status;
  logic [6:0]    bank_ptr_ff;
  logic [7:0]    port5_ff;
  logic [7:0]    port6_ff;
  logic [1:0]    port7_ff;
  logic [2:0]    ovf_ff;
  logic [3:0]    cmp_meta_ff;
  logic [3:0]    cmp_ff;
  logic [7:0]    ram_ff [`PCS_RAM_WORDS];
  logic          push;
  logic          pop;
  logic          pc_changed;
  // comparator levels come from analog pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta_ff <= 4'h0;
      cmp_ff      <= 4'h0;
    end else begin
      cmp_meta_ff <= comparator_result;
      cmp_ff      <= cmp_meta_ff;
    end
  end
  logic        aw_have_ff;
  logic        w_have_ff;
  logic [5:0]  aw_idx_ff;
  logic        aw_bad_ff;
  logic [7:0]  w_byte_ff;
  logic        w_lane_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [7:0]  rbyte_ff;
  wire aw_take = s_axi_awvalid && awready_ff;
  wire w_take  = s_axi_wvalid && wready_ff;
  wire ar_take = s_axi_arvalid && arready_ff;
  wire wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
  function automatic logic [5:0] eff_addr(input logic [5:0] a, input logic [6:0] ptr);
    eff_addr = (a == `PCS_IDX_INDIRECT) ? ptr[5:0] : a;
  endfunction : eff_addr
  // bank 1 sits 32 words above bank 0
  function automatic logic [6:0] ram_index(input logic [5:0] a, input logic bank);
    if (a < `PCS_IDX_BANKED) begin
      ram_index = {1'b0, a} - 7'h10;
    end else begin
      ram_index = 7'h10 + {1'b0, bank, 5'h00} - 7'h20 + {1'b0, a};
    end
  endfunction : ram_index
  wire [5:0] wr_eff   = eff_addr(aw_idx_ff, bank_ptr_ff);
  wire [5:0] rd_eff   = eff_addr(s_axi_araddr[7:2], bank_ptr_ff);
  wire [6:0] wr_ram   = ram_index(wr_eff, bank_ptr_ff[`PCS_BANK_BIT]);
  wire [6:0] rd_ram   = ram_index(rd_eff, bank_ptr_ff[`PCS_BANK_BIT]);
  wire       wr_is_ram = wr_eff >= `PCS_IDX_RAM_LO;
  wire       rd_is_ram = rd_eff >= `PCS_IDX_RAM_LO;
  wire       rd_bad   = s_axi_araddr[1:0] != 2'b00;
  function automatic logic mapped(input logic [5:0] a);
    mapped = (a >= `PCS_IDX_PC_LOW && a <= `PCS_IDX_PORT7) ||
             a == `PCS_IDX_CMP_STAT || a >= `PCS_IDX_RAM_LO || a == `PCS_IDX_INDIRECT;
  endfunction : mapped
  wire wr_ok  = wr_fire && !aw_bad_ff && mapped(aw_idx_ff) && w_lane_ff;
  wire wr_hit = wr_ok && wr_eff != `PCS_IDX_INDIRECT;
  wire sw_pc  = wr_hit && wr_eff == `PCS_IDX_PC_LOW;
  wire sw_st  = wr_hit && wr_eff == `PCS_IDX_STATUS;
  wire sw_cs  = wr_hit && wr_eff == `PCS_IDX_CMP_STAT;
  logic [7:0] rd_val;
  always_comb begin
    rd_val = `PCS_BYTE_RESET;
    if (rd_is_ram) begin
      rd_val = ram_ff[rd_ram];
    end else begin
      unique case (rd_eff)
        `PCS_IDX_PC_LOW:   rd_val = pc_ff[7:0];
        `PCS_IDX_STATUS:   rd_val = status_ff;
        `PCS_IDX_BANK_PTR: rd_val = {1'b0, bank_ptr_ff};
        `PCS_IDX_PORT5:    rd_val = port5_ff;
        `PCS_IDX_PORT6:    rd_val = port6_ff;
        `PCS_IDX_PORT7:    rd_val = {6'h00, port7_ff};
        `PCS_IDX_CMP_STAT: rd_val = {cmp_ff, 1'b0, ovf_ff};
        default:           rd_val = `PCS_BYTE_RESET;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      aw_idx_ff  <= 6'h00;
      aw_bad_ff  <= 1'b0;
      w_byte_ff  <= 8'h00;
      w_lane_ff  <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `PCS_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_ff <= 1'b1;
        awready_ff <= 1'b0;
        aw_idx_ff  <= s_axi_awaddr[7:2];
        aw_bad_ff  <= s_axi_awaddr[1:0] != 2'b00;
      end
      if (w_take) begin
        w_have_ff <= 1'b1;
        wready_ff <= 1'b0;
        w_byte_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (!aw_bad_ff && mapped(aw_idx_ff)) ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `PCS_RESP_OKAY;
      rbyte_ff   <= `PCS_BYTE_RESET;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rbyte_ff   <= rd_val;
      rresp_ff   <= (!rd_bad && mapped(s_axi_araddr[7:2])) ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end
  wire       exec = instr_valid && ready_ff;
  wire [10:0] pc_inc = pc_ff + 11'h001;
  wire [10:0] pc_sum = pc_ff + {3'b000, instr.acc};
  wire       page   = status_ff[`PCS_ST_PAGE];
  always_comb begin
    nxt_pc     = pc_ff;
    push       = 1'b0;
    pop        = 1'b0;
    pc_changed = 1'b0;
    if (exec) begin
      unique case (instr.op)
        PCS_OP_JUMP: begin
          nxt_pc     = {page, instr.operand};
          pc_changed = 1'b1;
        end
        PCS_OP_CALL: begin
          nxt_pc     = {page, instr.operand};
          push       = 1'b1;
          pc_changed = 1'b1;
        end
        PCS_OP_RETURN: begin
          nxt_pc     = stack_ff[sp_ff - SPW'(1)];
          pop        = 1'b1;
          pc_changed = 1'b1;
        end
        // add, then clear bits 8 and 9
        PCS_OP_ADD_PC: begin
          nxt_pc     = {page, 2'b00, pc_sum[7:0]};
          pc_changed = 1'b1;
        end
        PCS_OP_MOV_PC: begin
          nxt_pc     = {page, 2'b00, instr.acc};
          pc_changed = 1'b1;
        end
        PCS_OP_WRITE_PC: begin
          nxt_pc     = {page, 2'b00, instr.value};
          pc_changed = 1'b1;
        end
        PCS_OP_INT_ENTRY: begin
          nxt_pc     = {1'b0, instr.operand};
          push       = 1'b1;
          pc_changed = 1'b1;
        end
        default: nxt_pc = pc_inc;
      endcase
    end else if (sw_pc) begin
      nxt_pc     = {page, 2'b00, w_byte_ff};
      pc_changed = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_ff    <= `PCS_PC_RESET;
      ready_ff <= 1'b1;
    end else begin
      pc_ff    <= nxt_pc;
      ready_ff <= !pc_changed;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_ff <= '0;
    end else if (push) begin
      sp_ff <= sp_ff + SPW'(1);
    end else if (pop) begin
      sp_ff <= sp_ff - SPW'(1);
    end
  end
  for (genvar gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stack_ff[gi] <= `PCS_PC_RESET;
      end else if (push && sp_ff == SPW'(gi)) begin
        stack_ff[gi] <= pc_inc;
      end
    end
  end
  wire op_sleep = exec && instr.op == PCS_OP_SLEEP;
  wire op_watchdog_clear_instruction  = exec && instr.op == PCS_OP_WDT_CLEAR;
  wire op_alu   = exec && instr.op == PCS_OP_ALU;
  always_comb begin
    nxt_status = status_ff;
    if (sw_st) begin
      nxt_status = (status_ff & ~`PCS_ST_SW_MASK) | (w_byte_ff & `PCS_ST_SW_MASK);
    end
    if (op_alu) begin
      nxt_status[`PCS_ST_ZERO]   = instr.value == 8'h00;
      nxt_status[`PCS_ST_HCARRY] = instr.half_carry;
      nxt_status[`PCS_ST_CARRY]  = instr.carry;
    end
    if (wake_info.wake) begin
      nxt_status[`PCS_ST_RST] = wake_info.by_change;
    end
    if (wake_info.wdt_timeout) begin
      nxt_status[`PCS_ST_TOUT] = 1'b0;
    end
    if (op_sleep || op_watchdog_clear_instruction) begin
      nxt_status[`PCS_ST_TOUT] = 1'b1;
    end
    if (op_sleep) begin
      nxt_status[`PCS_ST_PDOWN] = 1'b0;
    end else if (op_watchdog_clear_instruction) begin
      nxt_status[`PCS_ST_PDOWN] = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= `PCS_ST_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_ff <= 3'b000;
    end else if (sw_cs) begin
      ovf_ff <= (ovf_ff & w_byte_ff[2:0]) | counter_overflow;
    end else begin
      ovf_ff <= ovf_ff | counter_overflow;
    end
  end
  wire [7:0] p5_mask = SMALL_PORT5 ? `PCS_PORT5_SMALL : 8'hFF;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_ptr_ff <= 7'h00;
      port5_ff    <= `PCS_BYTE_RESET;
      port6_ff    <= `PCS_BYTE_RESET;
      port7_ff    <= 2'b00;
    end else if (wr_hit) begin
      unique case (wr_eff)
        `PCS_IDX_BANK_PTR: bank_ptr_ff <= w_byte_ff[6:0];
        `PCS_IDX_PORT5:    port5_ff <= w_byte_ff & p5_mask;
        `PCS_IDX_PORT6:    port6_ff <= w_byte_ff;
        `PCS_IDX_PORT7:    port7_ff <= 2'(w_byte_ff & `PCS_PORT7_MASK);
        default:           bank_ptr_ff <= bank_ptr_ff;
      endcase
    end
  end
  // general registers hold no reset value
  always_ff @(posedge aclk) begin
    if (wr_hit && wr_is_ram) begin
      ram_ff[wr_ram] <= w_byte_ff;
    end
  end
  assign s_axi_awready          = awready_ff;
  assign s_axi_wready           = wready_ff;
  assign s_axi_bvalid           = bvalid_ff;
  assign s_axi_bresp            = bresp_ff;
  assign s_axi_arready          = arready_ff;
  assign s_axi_rvalid           = rvalid_ff;
  assign s_axi_rresp            = rresp_ff;
  assign s_axi_rdata            = {24'h00_0000, rbyte_ff};
  assign instr_ready            = ready_ff;
  assign rom_addr               = pc_ff;
  assign control_segment_select = status_ff[`PCS_ST_SEG];
  assign port_five_out          = port5_ff;
  assign port_six_out           = port6_ff;
  assign port_seven_out         = port7_ff;
endmodule : pcs_core
`default_nettype wire

// ==== pcs_core_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcs_core_props (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire pcs_pkg::pcs_instr_t instr,
  input wire logic                instr_valid,
  input wire logic                instr_ready,
  input wire logic [10:0]         rom_addr
);
  import pcs_pkg::*;
  wire logic tk = instr_valid && instr_ready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pc_reset_a: assert property (
    $rose(aresetn) |-> rom_addr == 11'h000)
    else $error("counter not cleared by reset");
  jump_low_a: assert property (
    tk && instr.op == PCS_OP_JUMP |=> rom_addr[9:0] == $past(instr.operand))
    else $error("jump target wrong");
  call_low_a: assert property (
    tk && instr.op == PCS_OP_CALL |=> rom_addr[9:0] == $past(instr.operand))
    else $error("call target wrong");
  // call then return straight after must land on the word after the call
  ret_restore_a: assert property (
    (tk && instr.op == PCS_OP_CALL) ##2 (tk && instr.op == PCS_OP_RETURN)
    |=> rom_addr == $past(rom_addr, 3) + 11'h001)
    else $error("return address wrong");
  add_pc_a: assert property (
    tk && instr.op == PCS_OP_ADD_PC
    |=> rom_addr[9:0] == {2'b00, 8'($past(rom_addr) + 11'($past(instr.acc)))})
    else $error("computed add wrong");
  mov_pc_a: assert property (
    tk && instr.op == PCS_OP_MOV_PC |=> rom_addr[9:0] == {2'b00, $past(instr.acc)})
    else $error("accumulator move wrong");
  write_pc_a: assert property (
    tk && instr.op == PCS_OP_WRITE_PC |=> rom_addr[9:0] == {2'b00, $past(instr.value)})
    else $error("counter write wrong");
  stall_once_a: assert property (
    tk && instr.op inside {PCS_OP_JUMP, PCS_OP_CALL, PCS_OP_RETURN, PCS_OP_ADD_PC,
      PCS_OP_MOV_PC, PCS_OP_WRITE_PC, PCS_OP_INT_ENTRY} |=> !instr_ready ##1 instr_ready)
    else $error("dead cycle missing or long");
  step_next_a: assert property (
    tk && instr.op inside {PCS_OP_STEP, PCS_OP_SLEEP, PCS_OP_WDT_CLEAR, PCS_OP_ALU}
    |=> instr_ready && rom_addr == $past(rom_addr) + 11'h001)
    else $error("plain step wrong");
endmodule : pcs_core_props
bind pcs_core pcs_core_props i_props (.aclk(aclk), .aresetn(aresetn), .instr(instr),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .rom_addr(rom_addr));
`default_nettype wire

// ==== pcs_rom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcs_rom_model (
  input  wire logic                aclk,
  input  wire logic                instr_ready,
  output var  pcs_pkg::pcs_instr_t instr,
  output var  logic                instr_valid
);
  import pcs_pkg::*;
  initial begin
    instr = '0;
    instr_valid = 1'b0;
  end
  // idle word is noise so a stale instruction is never trusted
  task automatic idle();
    instr_valid <= 1'b0;
    instr <= pcs_instr_t'($urandom);
  endtask : idle
  // random gap models a slow fetch; a refused word is held until taken
  task automatic issue(input pcs_instr_t i);
    if ($urandom_range(1, 0) == 1) begin
      idle();
      @(posedge aclk);
    end
    instr <= i;
    instr_valid <= 1'b1;
    do @(posedge aclk); while (!instr_ready);
  endtask : issue
endmodule : pcs_rom_model
`default_nettype wire

// ==== pcs_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcs_core_tb;
  import pcs_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, p5, p6, r;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, iv, ir, seg, tk_d = 1'b0;
  logic [1:0] bresp, rresp, p7;
  logic [3:0] wstrb = 4'hf;
  logic [10:0] rom_addr, pc;
  pcs_instr_t instr;
  pcs_wake_t wake = '0;
  logic [3:0] cmp = 4'h0;
  logic [2:0] ovf = 3'h0;
  logic [33:0] q[$];
  logic [10:0] pq[$], stk[$];
  logic [1:0] bq[$];
  int error_cnt = 0, num_checks = 0;

  always #20 aclk = ~aclk;

  pcs_core i_pcs_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .instr(instr),
    .instr_valid(iv), .instr_ready(ir), .rom_addr(rom_addr), .wake_info(wake),
    .comparator_result(cmp), .counter_overflow(ovf), .control_segment_select(seg),
    .port_five_out(p5), .port_six_out(p6), .port_seven_out(p7));
  pcs_rom_model i_pcs_rom_model (.aclk(aclk), .instr_ready(ir), .instr(instr),
    .instr_valid(iv));

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // waits for the answer however long it takes; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
    i_pcs_rom_model.idle();
    @(posedge aclk);
    bq.push_back(er);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
    i_pcs_rom_model.idle();
    @(posedge aclk);
    q.push_back({er, 24'h00_0000, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  task automatic ex(input pcs_op_t op, input logic [9:0] o, input logic [7:0] a,
                    input logic [7:0] v, input logic [10:0] e);
    pc = e;
    pq.push_back(e);
    i_pcs_rom_model.issue('{op, o, a, v, a[1], a[0]});
  endtask : ex

  task automatic pulse(input logic [2:0] w, input logic [2:0] ov);
    i_pcs_rom_model.idle();
    @(posedge aclk);
    wake <= pcs_wake_t'(w);
    ovf <= ov;
    @(posedge aclk);
    wake <= '0;
    ovf <= 3'h0;
  endtask : pulse

  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, q.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (tk_d) chk({23'h0, rom_addr}, {23'h0, pq.pop_front()});
    tk_d <= iv && ir;
  end

  // far beyond the few hundred cycles the sequence needs
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end

  initial begin
    void'($urandom(67));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h0c, 8'h18);
    rd(8'h08, 8'h00);
    rd(8'h24, 8'h00);
    rd(8'h20, 8'h00, 2'b10);
    wr(8'h0d, 8'h55, 2'b10);
    $display("done: reset values");
    wr(8'h0c, 8'h20);
    rd(8'h0c, 8'h38);
    ex(PCS_OP_JUMP, 10'h155, 8'h00, 8'h00, 11'h555);
    ex(PCS_OP_CALL, 10'h0aa, 8'h00, 8'h00, 11'h4aa);
    wr(8'h0c, 8'h00);
    ex(PCS_OP_RETURN, 10'h000, 8'h00, 8'h00, 11'h556);
    ex(PCS_OP_STEP, 10'h000, 8'h00, 8'h00, 11'h557);
    r = 8'($urandom);
    ex(PCS_OP_MOV_PC, 10'h3ff, r, 8'h00, {3'b000, r});
    ex(PCS_OP_WRITE_PC, 10'h000, 8'h00, 8'h7e, 11'h07e);
    ex(PCS_OP_ADD_PC, 10'h000, 8'h10, 8'h00, 11'h08e);
    ex(PCS_OP_INT_ENTRY, 10'h004, 8'h00, 8'h00, 11'h004);
    ex(PCS_OP_RETURN, 10'h000, 8'h00, 8'h00, 11'h08f);
    for (int k = 0; k < 8; k++) begin
      stk.push_back(pc + 11'h001);
      ex(PCS_OP_CALL, 10'h200 + 10'(k), 8'h00, 8'h00, {1'b0, 10'h200 + 10'(k)});
    end
    for (int k = 0; k < 8; k++) ex(PCS_OP_RETURN, 10'h000, 8'h00, 8'h00, stk.pop_back());
    $display("done: counter and stack");
    ex(PCS_OP_SLEEP, 10'h000, 8'h00, 8'h00, pc + 11'h001);
    rd(8'h0c, 8'h10);
    pulse(3'b001, 3'h0);
    rd(8'h0c, 8'h00);
    ex(PCS_OP_WDT_CLEAR, 10'h000, 8'h00, 8'h00, pc + 11'h001);
    rd(8'h0c, 8'h18);
    ex(PCS_OP_ALU, 10'h000, 8'h02, 8'h00, pc + 11'h001);
    rd(8'h0c, 8'h1e);
    ex(PCS_OP_ALU, 10'h000, 8'h01, 8'h05, pc + 11'h001);
    rd(8'h0c, 8'h19);
    pulse(3'b110, 3'h0);
    rd(8'h0c, 8'h99);
    pulse(3'b100, 3'h0);
    rd(8'h0c, 8'h19);
    wr(8'h0c, 8'h40);
    chk({33'h0, seg}, {33'h0, 1'b1});
    $display("done: status");
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h7f);
    wr(8'h10, 8'h15);
    wr(8'h00, 8'ha5);
    rd(8'h54, 8'ha5);
    wr(8'h10, 8'h60);
    wr(8'h00, 8'h3c);
    wr(8'h10, 8'h20);
    wr(8'h80, 8'h11);
    rd(8'h00, 8'h11);
    wr(8'h10, 8'h60);
    rd(8'h80, 8'h3c);
    $display("done: banks");
    r = 8'($urandom);
    wr(8'h14, 8'hff);
    wr(8'h18, r);
    wr(8'h1c, 8'hff);
    rd(8'h1c, 8'h03);
    chk({16'h0, p5, p6, p7}, {16'h0, 8'hff, r, 2'b11});
    // a write with byte lane 0 off must leave the port alone
    wstrb <= 4'h0;
    wr(8'h18, 8'h00);
    wstrb <= 4'hf;
    rd(8'h18, r);
    cmp <= 4'ha;
    pulse(3'b000, 3'b101);
    rd(8'h24, 8'ha5);
    wr(8'h24, 8'h00);
    rd(8'h24, 8'ha0);
    wr(8'h08, 8'h33);
    chk({23'h0, rom_addr}, {23'h0, 11'h033});
    $display("done: ports and flags");
    // reset again with a non-zero counter and a changed status
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h08, 8'h00);
    rd(8'h0c, 8'h18);
    chk({16'h0, p5, p6, p7}, {16'h0, 8'h00, 8'h00, 2'b00});
    $display("done: second reset");
    stop_test();
  end
endmodule : pcs_core_tb
`default_nettype wire
